/* rtl/cke_cmd_pkg.sv */
// package: command encodings, states, field positions and timing counts for the command decoder
//
// Behaviour
// RULE_01: cs low, ras cas we high is nop
// RULE_02: nop never ends a running burst
// RULE_03: cs high is deselect, acts as nop
// RULE_04: clock change only in self-refresh or precharge power-down
// RULE_05: controller waits two clocks after trp, taofd
// RULE_06: controller gives stable clock before raising cke
// RULE_07: controller issues dll reset after power-down exit
// RULE_08: odt held off 200 clocks during relock
// RULE_09: async cke drop loses array contents
// RULE_10: after async drop controller fully reinitialises
// RULE_11: decode cs ras cas we with cke
// RULE_12: mode register set: bank selects register, address opcode
// RULE_13: bank selects target; a10 auto-precharge or all
// RULE_14: power-down entry and exit with nop/deselect
// RULE_15: no refresh during power-down
// RULE_16: refresh with cke falling enters self-refresh
// RULE_17: length four bursts always complete
// RULE_18: odt ignored by cke states; off in self-refresh
// RULE_19: controller keeps cke steady three clocks
// RULE_20: undefined cke/command combinations change nothing; a cke fall not accepted as an entry goes to ST_LOST
package cke_cmd_pkg;

    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int AP_BIT = 10;
    localparam int NUM_BANKS = 8;
    localparam int BURST_LEN = 4;
    // a burst of four occupies two clocks on a double-rate bus
    localparam int BURST_CYCLES = BURST_LEN / 2;
    localparam int RELOCK_CYCLES = 200;
    localparam int CKE_MIN_CYCLES = 3;

    localparam logic [3:0] PAT_MRS = 4'h0;
    localparam logic [3:0] PAT_REF = 4'h1;
    localparam logic [3:0] PAT_PRE = 4'h2;
    localparam logic [3:0] PAT_ACT = 4'h3;
    localparam logic [3:0] PAT_WR = 4'h4;
    localparam logic [3:0] PAT_RD = 4'h5;
    localparam logic [3:0] PAT_NOP = 4'h7;

    localparam logic [2:0] EMR1_SEL = 3'h1;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_MRS = 4'h1,
        CMD_REFRESH = 4'h2,
        CMD_PRECHARGE = 4'h3,
        CMD_ACTIVATE = 4'h4,
        CMD_WRITE = 4'h5,
        CMD_READ = 4'h6,
        CMD_NOP = 4'h7,
        CMD_SR_ENTRY = 4'h8,
        CMD_SR_EXIT = 4'h9,
        CMD_PD_ENTRY = 4'ha,
        CMD_PD_EXIT = 4'hb,
        CMD_ILLEGAL = 4'hc
    } cmd_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h0,
        ST_PRECHARGE_PD = 3'h1,
        ST_ACTIVE_PD = 3'h2,
        ST_SELF_REFRESH = 3'h3,
        ST_LOST = 3'h4
    } power_state_t;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } pins_t;

    typedef struct packed {
        cmd_t cmd;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic all_banks;
        logic auto_pre;
    } decoded_t;

endpackage

/* rtl/cmd_decoder.sv */
// command pin decoder: maps cke history and control pins to one command
`timescale 1ns/10ps
module cmd_decoder (
    // sampled pins
    input wire cke_cmd_pkg::pins_t pins,
    input wire logic cke_prev,
    // decoded command
    output cke_cmd_pkg::decoded_t dec
);

    function automatic cke_cmd_pkg::cmd_t decode_pat(input logic [3:0] pat);
        case (pat)
            cke_cmd_pkg::PAT_MRS: decode_pat = cke_cmd_pkg::CMD_MRS;
            cke_cmd_pkg::PAT_REF: decode_pat = cke_cmd_pkg::CMD_REFRESH;
            cke_cmd_pkg::PAT_PRE: decode_pat = cke_cmd_pkg::CMD_PRECHARGE;
            cke_cmd_pkg::PAT_ACT: decode_pat = cke_cmd_pkg::CMD_ACTIVATE;
            cke_cmd_pkg::PAT_WR: decode_pat = cke_cmd_pkg::CMD_WRITE;
            cke_cmd_pkg::PAT_RD: decode_pat = cke_cmd_pkg::CMD_READ;
            cke_cmd_pkg::PAT_NOP: decode_pat = cke_cmd_pkg::CMD_NOP;
            default: decode_pat = cke_cmd_pkg::CMD_ILLEGAL; // RULE_20
        endcase
    endfunction

    logic [3:0] pat;
    logic idle_cmd;
    cke_cmd_pkg::cmd_t base;

    always_comb begin
        pat = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
        // cs high: ras, cas, we are ignored
        idle_cmd = pins.cs_n || (pat == cke_cmd_pkg::PAT_NOP); // RULE_03 RULE_01
        base = pins.cs_n ? cke_cmd_pkg::CMD_NOP : decode_pat(pat); // RULE_11
        dec.bank = pins.ba; // RULE_12 RULE_13
        dec.addr = pins.addr;
        dec.all_banks = pins.addr[cke_cmd_pkg::AP_BIT]; // RULE_13
        dec.auto_pre = pins.addr[cke_cmd_pkg::AP_BIT];
        case ({cke_prev, pins.cke})
            2'b11: dec.cmd = base;
            2'b10: begin
                if (idle_cmd) begin
                    dec.cmd = cke_cmd_pkg::CMD_PD_ENTRY; // RULE_14
                end else if (!pins.cs_n && pat == cke_cmd_pkg::PAT_REF) begin
                    dec.cmd = cke_cmd_pkg::CMD_SR_ENTRY; // RULE_16
                end else begin
                    dec.cmd = cke_cmd_pkg::CMD_ILLEGAL; // RULE_20
                end
            end
            2'b01: dec.cmd = idle_cmd ? cke_cmd_pkg::CMD_PD_EXIT : cke_cmd_pkg::CMD_ILLEGAL;
            2'b00: dec.cmd = cke_cmd_pkg::CMD_NONE;
            default: dec.cmd = cke_cmd_pkg::CMD_ILLEGAL;
        endcase
    end

endmodule // cmd_decoder

/* rtl/cke_cmd_ctrl.sv */
// command interpreter and clock-enable state control of the memory device
`timescale 1ns/10ps
module cke_cmd_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command pins from the controller
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic odt,
    // decoded command, one-cycle strobe
    output logic cmd_valid,
    output cke_cmd_pkg::decoded_t cmd_out,
    // device state
    output cke_cmd_pkg::power_state_t power_state,
    output logic [7:0] bank_open,
    output logic burst_busy,
    output logic burst_is_write,
    output logic mode_wr,
    output logic [2:0] mode_sel,
    output logic [13:0] mode_opcode,
    output logic dll_relocking,
    output logic odt_enable,
    output logic refresh_enable,
    output logic contents_lost,
    output logic illegal_cmd
);

    cke_cmd_pkg::pins_t pins;
    cke_cmd_pkg::decoded_t dec;
    logic cke_prev_reg, cke_prev_next;

    always_comb begin
        pins.cke = cke;
        pins.cs_n = cs_n;
        pins.ras_n = ras_n;
        pins.cas_n = cas_n;
        pins.we_n = we_n;
        pins.ba = ba;
        pins.addr = addr;
    end

    cmd_decoder u_dec (
        .pins(pins),
        .cke_prev(cke_prev_reg),
        .dec(dec)
    );

    cke_cmd_pkg::power_state_t state_reg, state_next;
    logic [7:0] bank_reg, bank_next;
    logic [1:0] burst_cnt_reg, burst_cnt_next;
    logic burst_wr_reg, burst_wr_next;
    logic [7:0] relock_reg, relock_next;
    logic lost_reg, lost_next;
    logic illegal_reg, illegal_next;
    logic valid_reg, valid_next;
    cke_cmd_pkg::decoded_t cmd_reg, cmd_next;
    logic mode_wr_reg, mode_wr_next;
    logic [2:0] mode_sel_reg, mode_sel_next;
    logic [13:0] mode_op_reg, mode_op_next;
    logic odt_reg, odt_next;
    logic accepted;

    always_comb begin
        cke_prev_next = cke;
        state_next = state_reg;
        bank_next = bank_reg;
        burst_cnt_next = burst_cnt_reg;
        burst_wr_next = burst_wr_reg;
        relock_next = relock_reg;
        lost_next = lost_reg;
        illegal_next = 1'b0;
        valid_next = 1'b0;
        cmd_next = dec;
        mode_wr_next = 1'b0;
        mode_sel_next = mode_sel_reg;
        mode_op_next = mode_op_reg;
        accepted = 1'b0;

        // bursts count down regardless of nop or deselect
        if (burst_cnt_reg != 2'h0) begin
            burst_cnt_next = burst_cnt_reg - 2'h1; // RULE_02 RULE_17
        end
        if (relock_reg != 8'h00) begin
            relock_next = relock_reg - 8'h01;
        end

        case (state_reg)
            cke_cmd_pkg::ST_ACTIVE: begin
                case (dec.cmd)
                    cke_cmd_pkg::CMD_MRS: begin
                        accepted = 1'b1;
                        mode_wr_next = 1'b1; // RULE_12
                        mode_sel_next = dec.bank;
                        mode_op_next = dec.addr;
                        // opcode bit 8 of the first extended register requests a dll reset
                        if (dec.bank == cke_cmd_pkg::EMR1_SEL && dec.addr[8]) begin
                            relock_next = 8'(cke_cmd_pkg::RELOCK_CYCLES); // RULE_08
                        end
                    end
                    cke_cmd_pkg::CMD_REFRESH: accepted = 1'b1;
                    cke_cmd_pkg::CMD_ACTIVATE: begin
                        accepted = 1'b1;
                        bank_next[dec.bank] = 1'b1; // RULE_13
                    end
                    cke_cmd_pkg::CMD_PRECHARGE: begin
                        accepted = 1'b1;
                        if (dec.all_banks) begin
                            bank_next = 8'h00; // RULE_13
                        end else begin
                            bank_next[dec.bank] = 1'b0;
                        end
                    end
                    cke_cmd_pkg::CMD_READ, cke_cmd_pkg::CMD_WRITE: begin
                        // a new column command in the first clock of a burst would cut it short
                        if (burst_cnt_reg > 2'h1) begin
                            illegal_next = 1'b1; // RULE_17
                        end else begin
                            accepted = 1'b1;
                            burst_cnt_next = 2'(cke_cmd_pkg::BURST_CYCLES);
                            burst_wr_next = (dec.cmd == cke_cmd_pkg::CMD_WRITE);
                            if (dec.auto_pre) begin
                                bank_next[dec.bank] = 1'b0; // RULE_13
                            end
                        end
                    end
                    cke_cmd_pkg::CMD_NOP: accepted = 1'b1; // RULE_01 RULE_02
                    // reset takes the earlier cke as low, so a held low and the first rise are benign
                    cke_cmd_pkg::CMD_NONE: accepted = 1'b1; // RULE_14
                    cke_cmd_pkg::CMD_PD_EXIT: accepted = 1'b1; // RULE_14
                    cke_cmd_pkg::CMD_PD_ENTRY: begin
                        accepted = 1'b1;
                        state_next = (bank_reg == 8'h00) ? cke_cmd_pkg::ST_PRECHARGE_PD
                                                         : cke_cmd_pkg::ST_ACTIVE_PD; // RULE_14
                    end
                    cke_cmd_pkg::CMD_SR_ENTRY: begin
                        if (bank_reg == 8'h00) begin
                            accepted = 1'b1;
                            state_next = cke_cmd_pkg::ST_SELF_REFRESH; // RULE_16 RULE_04
                        end else begin
                            illegal_next = 1'b1; // RULE_20
                        end
                    end
                    default: illegal_next = 1'b1; // RULE_20
                endcase
                // cke low that is not a legal entry: asynchronous drop
                if (!cke && !accepted) begin
                    state_next = cke_cmd_pkg::ST_LOST; // RULE_09
                    lost_next = 1'b1;
                end
            end
            cke_cmd_pkg::ST_PRECHARGE_PD, cke_cmd_pkg::ST_ACTIVE_PD: begin
                // no refresh here; duration is the controller's concern
                if (dec.cmd == cke_cmd_pkg::CMD_PD_EXIT) begin
                    accepted = 1'b1;
                    state_next = cke_cmd_pkg::ST_ACTIVE; // RULE_14
                end else if (cke) begin
                    illegal_next = 1'b1; // RULE_20
                end
            end
            cke_cmd_pkg::ST_SELF_REFRESH: begin
                if (dec.cmd == cke_cmd_pkg::CMD_PD_EXIT) begin
                    accepted = 1'b1;
                    cmd_next.cmd = cke_cmd_pkg::CMD_SR_EXIT;
                    state_next = cke_cmd_pkg::ST_ACTIVE; // RULE_16
                end else if (cke) begin
                    illegal_next = 1'b1; // RULE_20
                end
            end
            cke_cmd_pkg::ST_LOST: begin
                // leaves only through a mode register write of a new init sequence
                if (cke_prev_reg && dec.cmd == cke_cmd_pkg::CMD_MRS) begin
                    accepted = 1'b1;
                    mode_wr_next = 1'b1;
                    mode_sel_next = dec.bank;
                    mode_op_next = dec.addr;
                    lost_next = 1'b0; // RULE_10
                    bank_next = 8'h00;
                    state_next = cke_cmd_pkg::ST_ACTIVE;
                end
            end
            default: state_next = cke_cmd_pkg::ST_ACTIVE;
        endcase
        valid_next = accepted && (dec.cmd != cke_cmd_pkg::CMD_NONE);
        // odt plays no part in state; termination is off in self-refresh and relock
        odt_next = odt && (state_next != cke_cmd_pkg::ST_SELF_REFRESH)
                   && (relock_next == 8'h00); // RULE_18 RULE_08
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cke_prev_reg <= 1'b0;
            state_reg <= cke_cmd_pkg::ST_ACTIVE;
            bank_reg <= 8'h00;
            burst_cnt_reg <= 2'h0;
            burst_wr_reg <= 1'b0;
            relock_reg <= 8'h00;
            lost_reg <= 1'b0;
            illegal_reg <= 1'b0;
            valid_reg <= 1'b0;
            cmd_reg <= '0;
            mode_wr_reg <= 1'b0;
            mode_sel_reg <= 3'h0;
            mode_op_reg <= 14'h0000;
            odt_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke_prev_next;
            state_reg <= state_next;
            bank_reg <= bank_next;
            burst_cnt_reg <= burst_cnt_next;
            burst_wr_reg <= burst_wr_next;
            relock_reg <= relock_next;
            lost_reg <= lost_next;
            illegal_reg <= illegal_next;
            valid_reg <= valid_next;
            cmd_reg <= cmd_next;
            mode_wr_reg <= mode_wr_next;
            mode_sel_reg <= mode_sel_next;
            mode_op_reg <= mode_op_next;
            odt_reg <= odt_next;
        end
    end

    logic busy_reg;
    logic relock_busy_reg;
    logic refresh_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            relock_busy_reg <= 1'b0;
            refresh_reg <= 1'b0;
        end else begin
            busy_reg <= (burst_cnt_next != 2'h0);
            relock_busy_reg <= (relock_next != 8'h00);
            // internal refresh only in self-refresh, never in power-down
            refresh_reg <= (state_next == cke_cmd_pkg::ST_SELF_REFRESH); // RULE_15
        end
    end

    assign cmd_valid = valid_reg;
    assign cmd_out = cmd_reg;
    assign power_state = state_reg;
    assign bank_open = bank_reg;
    assign burst_busy = busy_reg;
    assign burst_is_write = burst_wr_reg;
    assign mode_wr = mode_wr_reg;
    assign mode_sel = mode_sel_reg;
    assign mode_opcode = mode_op_reg;
    assign dll_relocking = relock_busy_reg;
    assign odt_enable = odt_reg;
    assign refresh_enable = refresh_reg;
    assign contents_lost = lost_reg;
    assign illegal_cmd = illegal_reg;

endmodule // cke_cmd_ctrl

/* test/ctrl_model.sv */
// controller-side model: plays queued commands, fills idle cycles with nop or deselect
`timescale 1ns/10ps
module ctrl_model (
    // clock
    input wire logic clk,
    // keep termination off while high
    input wire logic odt_quiet,
    // pins towards the device
    output cke_cmd_pkg::pins_t pins,
    output logic odt
);
    cke_cmd_pkg::pins_t cmd_q[$];
    logic [15:0] held = 16'h0000;

    initial begin
        pins = {1'b0, 4'h7, 3'h0, 14'h0000};
        odt = 1'b0;
    end

    task automatic send(input cke_cmd_pkg::pins_t q);
        cmd_q.push_back(q);
    endtask

    always @(posedge clk) begin
        cke_cmd_pkg::pins_t n;
        held = held + 16'h0001;
        // a cke change waits until the old level was sampled three times
        if (cmd_q.size() > 0 && (cmd_q[0].cke == pins.cke || held >= 16'h0003)) begin
            n = cmd_q.pop_front();
            if (n.cke != pins.cke)
                held = 16'h0000;
        end else begin
            // idle: nop or deselect, released lines keep toggling
            n = pins;
            n.cs_n = held[0];
            n.ras_n = held[0] ? held[1] : 1'b1;
            n.cas_n = held[0] ? ~held[1] : 1'b1;
            n.we_n = held[0] ? held[2] : 1'b1;
            n.ba = ~pins.ba;
            n.addr = ~pins.addr;
        end
        pins <= n;
        // termination stays off when told, e.g. around self-refresh entry
        odt <= odt_quiet ? 1'b0 : held[2];
    end
endmodule // ctrl_model

/* test/cke_cmd_sva.sv */
// assertions on the command interpreter ports
`timescale 1ns/10ps
module cke_cmd_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    // results
    input wire logic cmd_valid,
    input wire cke_cmd_pkg::decoded_t cmd_out,
    input wire cke_cmd_pkg::power_state_t power_state,
    input wire logic [7:0] bank_open,
    input wire logic burst_busy,
    input wire logic mode_wr,
    input wire logic [2:0] mode_sel,
    input wire logic [13:0] mode_opcode,
    input wire logic dll_relocking,
    input wire logic odt_enable,
    input wire logic refresh_enable,
    input wire logic illegal_cmd
);
    logic cke_q;
    logic cke_next;
    // mirrors the design: reset takes the earlier cke as low
    always_comb cke_next = rst_n ? cke : 1'b0;
    always_ff @(posedge clk) cke_q <= cke_next;
    wire run = cke_q & cke;
    wire quiet = cs_n | (ras_n & cas_n & we_n);
    wire [3:0] pat = {cs_n, ras_n, cas_n, we_n};
    wire act_st = power_state == cke_cmd_pkg::ST_ACTIVE;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_burst_run:
        assert property (cmd_valid && (cmd_out.cmd == cke_cmd_pkg::CMD_READ
            || cmd_out.cmd == cke_cmd_pkg::CMD_WRITE) |-> burst_busy ##1 burst_busy)
        else $error("burst cut short");
    chk_nop_quiet:
        assert property (run && quiet && act_st |=> !illegal_cmd && !mode_wr
            && $stable(bank_open))
        else $error("nop or deselect changed state");
    chk_act_open:
        assert property (run && act_st && pat == cke_cmd_pkg::PAT_ACT |=> cmd_valid
            && cmd_out.cmd == cke_cmd_pkg::CMD_ACTIVATE && bank_open[$past(ba)])
        else $error("activate not taken");
    chk_pre_all:
        assert property (run && act_st && pat == cke_cmd_pkg::PAT_PRE && addr[10]
            |=> bank_open == 8'h00)
        else $error("precharge all left a bank open");
    chk_mode_sel:
        assert property (run && pat == cke_cmd_pkg::PAT_MRS |=> mode_wr
            && mode_sel == $past(ba) && mode_opcode == $past(addr))
        else $error("mode write lost select or opcode");
    chk_pd_entry:
        assert property (cke_q && !cke && quiet && act_st && bank_open == 8'h00
            && !burst_busy |=> power_state == cke_cmd_pkg::ST_PRECHARGE_PD
            && cmd_valid && cmd_out.cmd == cke_cmd_pkg::CMD_PD_ENTRY)
        else $error("power-down entry missed");
    chk_sr_refresh:
        assert property (refresh_enable == (power_state == cke_cmd_pkg::ST_SELF_REFRESH))
        else $error("refresh outside self-refresh");
    chk_odt_gate:
        assert property (power_state == cke_cmd_pkg::ST_SELF_REFRESH || dll_relocking
            |-> !odt_enable)
        else $error("termination on while gated");
    chk_bad_fall:
        assert property (cke_q && !cke && !quiet && pat != cke_cmd_pkg::PAT_REF
            && act_st |=> illegal_cmd && power_state == cke_cmd_pkg::ST_LOST)
        else $error("cke drop with command not flagged");
    chk_undef_cmd:
        assert property (run && act_st && pat == 4'h6 |=> illegal_cmd && !cmd_valid
            && $stable(bank_open))
        else $error("undefined command acted on");
endmodule // cke_cmd_sva

bind cke_cmd_ctrl cke_cmd_sva chk (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .cmd_valid(cmd_valid), .cmd_out(cmd_out), .power_state(power_state),
    .bank_open(bank_open), .burst_busy(burst_busy), .mode_wr(mode_wr),
    .mode_sel(mode_sel), .mode_opcode(mode_opcode), .dll_relocking(dll_relocking),
    .odt_enable(odt_enable), .refresh_enable(refresh_enable), .illegal_cmd(illegal_cmd));

/* test/tb.sv */
// self-checking bench for the command interpreter
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic odt_quiet = 1'b1;
    cke_cmd_pkg::pins_t p;
    cke_cmd_pkg::decoded_t cmd_out;
    cke_cmd_pkg::power_state_t power_state;
    cke_cmd_pkg::cmd_t e_cmd;
    logic odt, cmd_valid, burst_busy, illegal_cmd, mode_wr, dll_relocking, contents_lost;
    logic pk = 1'b0, e_cv = 1'b0, e_il = 1'b0, e_mw = 1'b0, e_lost = 1'b0;
    logic burst_is_write, bw = 1'b0;
    logic [7:0] bank_open;
    logic [7:0] bk = 8'h00;
    logic [3:0] tbl [4] = '{4'h3, 4'h2, 4'h7, 4'h6};
    int mismatches = 0, checks_done = 0, cycles = 0, st = 0, busy = 0, i, r;
    int seed = 51;
    always #10 clk = ~clk;
    ctrl_model ctrl (.clk(clk), .odt_quiet(odt_quiet), .pins(p), .odt(odt));
    cke_cmd_ctrl DUT (.clk(clk), .rst_n(rst_n), .cke(p.cke), .cs_n(p.cs_n), .ras_n(p.ras_n),
        .cas_n(p.cas_n), .we_n(p.we_n), .ba(p.ba), .addr(p.addr), .odt(odt),
        .cmd_valid(cmd_valid), .cmd_out(cmd_out), .power_state(power_state),
        .bank_open(bank_open), .burst_busy(burst_busy), .burst_is_write(burst_is_write),
        .mode_wr(mode_wr),
        .mode_sel(), .mode_opcode(), .dll_relocking(dll_relocking), .odt_enable(),
        .refresh_enable(), .contents_lost(contents_lost), .illegal_cmd(illegal_cmd));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // reference model, advanced with the pins sampled at each edge
    task automatic step();
        logic [3:0] pat;
        logic nop;
        pat = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
        nop = p.cs_n | (pat == cke_cmd_pkg::PAT_NOP);
        e_cv = 1'b0;
        e_il = 1'b0;
        e_mw = 1'b0;
        if (pk && p.cke && st == 4) begin
            if (pat == cke_cmd_pkg::PAT_MRS) begin
                st = 0;
                e_lost = 1'b0;
                e_mw = 1'b1;
                e_cv = 1'b1;
                e_cmd = cke_cmd_pkg::CMD_MRS;
                bk = 8'h00;
            end
        end else if (pk && p.cke) begin
            e_cv = 1'b1;
            if (nop) e_cmd = cke_cmd_pkg::CMD_NOP;
            else if (pat == cke_cmd_pkg::PAT_ACT) begin
                e_cmd = cke_cmd_pkg::CMD_ACTIVATE;
                bk[p.ba] = 1'b1;
            end else if (pat == cke_cmd_pkg::PAT_PRE) begin
                e_cmd = cke_cmd_pkg::CMD_PRECHARGE;
                if (p.addr[10]) bk = 8'h00;
                else bk[p.ba] = 1'b0;
            end else if ((pat == cke_cmd_pkg::PAT_RD || pat == cke_cmd_pkg::PAT_WR) && busy < 2) begin
                e_cmd = (pat == cke_cmd_pkg::PAT_RD) ? cke_cmd_pkg::CMD_READ : cke_cmd_pkg::CMD_WRITE;
                if (p.addr[10]) bk[p.ba] = 1'b0;
                busy = 3;
                bw = (pat == cke_cmd_pkg::PAT_WR);
            end else if (pat == cke_cmd_pkg::PAT_MRS) begin
                e_cmd = cke_cmd_pkg::CMD_MRS;
                e_mw = 1'b1;
            end else if (pat == cke_cmd_pkg::PAT_REF) e_cmd = cke_cmd_pkg::CMD_REFRESH;
            else begin
                e_cv = 1'b0;
                e_il = 1'b1;
            end
        end else if (pk) begin
            e_cv = nop || (pat == cke_cmd_pkg::PAT_REF && bk == 8'h00);
            e_cmd = nop ? cke_cmd_pkg::CMD_PD_ENTRY : cke_cmd_pkg::CMD_SR_ENTRY;
            if (e_cv) st = nop ? ((bk != 8'h00) ? 2 : 1) : 3;
            else begin
                e_il = 1'b1;
                e_lost = 1'b1;
                st = 4;
            end
        end else if (p.cke) begin
            e_cv = (st < 4) && nop;
            e_il = (st < 4) && !nop;
            e_cmd = (st == 3) ? cke_cmd_pkg::CMD_SR_EXIT : cke_cmd_pkg::CMD_PD_EXIT;
            if (e_cv) st = 0;
        end
        pk = p.cke;
        busy = (busy > 0) ? busy - 1 : 0;
    endtask

    always @(posedge clk) begin
        if (rst_n) begin
            check(power_state, 16'(st));
            check(bank_open, bk);
            check(burst_busy, busy > 0);
            check(illegal_cmd, e_il);
            check(mode_wr, e_mw);
            check(contents_lost, e_lost);
            check(cmd_valid, e_cv);
            if (e_cv) check(cmd_out.cmd, e_cmd);
            check(burst_is_write, bw);
            step();
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // queue one command; a gap of zero leaves the next one back to back
    task automatic cmd(input logic k, input logic [3:0] pat, input logic [2:0] ba,
        input logic [13:0] a, input int gap);
        ctrl.send({k, pat, ba, a});
        if (gap > 0) begin
            for (int n = 0; n < 20 && ctrl.cmd_q.size() > 0; n++) @(posedge clk);
            repeat (gap) @(posedge clk);
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        odt_quiet <= 1'b0;
        cmd(1'b1, 4'h7, 3'h0, 14'h0000, 4);
        cmd(1'b1, cke_cmd_pkg::PAT_ACT, 3'h2, 14'($random(seed)), 1);
        cmd(1'b1, cke_cmd_pkg::PAT_ACT, 3'h5, 14'($random(seed)), 1);
        // read with auto-precharge, write refused mid-burst, then seamless write
        cmd(1'b1, cke_cmd_pkg::PAT_RD, 3'h2, 14'h0400, 0);
        cmd(1'b1, cke_cmd_pkg::PAT_WR, 3'h5, 14'h0000, 0);
        cmd(1'b1, cke_cmd_pkg::PAT_WR, 3'h5, 14'h0008, 4);
        cmd(1'b0, 4'h7, 3'h0, 14'h0000, 4);
        cmd(1'b1, 4'hf, 3'h0, 14'h0000, 4);
        cmd(1'b1, cke_cmd_pkg::PAT_PRE, 3'h0, 14'h0400, 2);
        cmd(1'b0, 4'hf, 3'h0, 14'h0000, 4);
        cmd(1'b1, 4'h7, 3'h0, 14'h0000, 4);
        for (i = 0; i < 4; i++) cmd(1'b1, cke_cmd_pkg::PAT_MRS, 3'(i), 14'($random(seed)), 2);
        // dll reset: relock window, termination noise must stay gated
        cmd(1'b1, cke_cmd_pkg::PAT_MRS, cke_cmd_pkg::EMR1_SEL, 14'h0100, 2);
        check(dll_relocking, 1'b1);
        repeat (cke_cmd_pkg::RELOCK_CYCLES) @(posedge clk);
        check(dll_relocking, 1'b0);
        cmd(1'b1, cke_cmd_pkg::PAT_REF, 3'h0, 14'h0000, 2);
        odt_quiet <= 1'b1;
        cmd(1'b0, cke_cmd_pkg::PAT_REF, 3'h0, 14'h0000, 8);
        cmd(1'b1, 4'h7, 3'h0, 14'h0000, 4);
        odt_quiet <= 1'b0;
        // cke dropped under an activate: contents lost until a mode write
        cmd(1'b0, cke_cmd_pkg::PAT_ACT, 3'h1, 14'h0000, 4);
        cmd(1'b1, 4'h7, 3'h0, 14'h0000, 4);
        cmd(1'b1, cke_cmd_pkg::PAT_MRS, 3'h0, 14'h0000, 4);
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            cmd(1'b1, tbl[r[1:0]], r[4:2], 14'(r >> 5), 1);
        end
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule // tb
